// ---- adc_offset_calibration_frame_tb_top.sv ----
// Self-checking bench for the offset calibration frame block.
// Assumes oc_pkg and the host model are compiled first.
`timescale 1ns/10ps

`define CHK(nm, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("BAD %s exp %h got %h", nm, e, g); \
  end \
end

// ==========================================================
// Bench top
module adc_offset_calibration_frame_tb_top
  import oc_pkg::*;
;
  logic             ref_clk;
  logic             rst_n;
  logic             sample_valid;
  logic             sample_ready;
  logic [RES_W-1:0] sample_data;
  logic [OFS_W-1:0] offset_meas;
  logic             cal_active;
  logic             cs_n;
  logic             sclk;
  logic             cal_seen;
  logic             first;
  oc_spi_in_t       spi_in;
  oc_sdo_t          spi_out;
  int               num_errors;
  int               num_checks;
  int               seed;
  int               ofs;
  logic [RES_W-1:0] q[$];

  assign spi_in.cs_n = cs_n;
  assign spi_in.sclk = sclk;

  oc_frame_ctrl oc_frame_ctrl_inst (
    .ref_clk      (ref_clk),
    .rst_n        (rst_n),
    .spi_in       (spi_in),
    .spi_out      (spi_out),
    .sample_valid (sample_valid),
    .sample_ready (sample_ready),
    .sample_data  (sample_data),
    .offset_meas  (offset_meas),
    .cal_active   (cal_active)
  );

  oc_host_model oc_host_model_inst (
    .cs_n     (cs_n),
    .sclk     (sclk),
    .sdo      (spi_out.sdo),
    .sdo_oe_n (spi_out.sdo_oe_n)
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // Model of the sample queue and calibration activity
  always @(posedge ref_clk) begin
    if (sample_valid === 1'b1 && sample_ready === 1'b1)
      q.push_back(sample_data);
    if (cal_active === 1'b1)
      cal_seen = 1'b1;
  end

  // ==========================================================
  // Tasks
  task automatic do_reset;
    rst_n = 1'b0;
    q.delete();
    first = 1'b1;
    ofs = 0;
    repeat (16) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic push(input logic [RES_W-1:0] d);
    @(posedge ref_clk);
    #1 sample_valid = 1'b1;
    sample_data = d;
    @(posedge ref_clk);
    #1 sample_valid = 1'b0;
  endtask

  task automatic set_ofs(input logic [OFS_W-1:0] v);
    @(posedge ref_clk);
    #1 offset_meas = v;
  endtask

  task automatic frame(input int n);
    logic [63:0]      got;
    logic [63:0]      exp;
    logic             on;
    logic             off;
    logic [RES_W-1:0] raw;
    int               r;
    exp = '0;
    cal_seen = 1'b0;
    if (!first) begin
      raw = (q.size() > 0) ? q.pop_front() : RES_EMPTY;
      r = int'(raw) - ofs;
      if (r < 0) r = 0;
      if (r > 4095) r = 4095;
      for (int k = 0; k < RES_W; k++) exp[2+k] = r[RES_W-1-k];
    end
    oc_host_model_inst.run_frame(n, got, on, off);
    `CHK("frame bits", exp, got)
    `CHK("drive on", 1'b0, on)
    `CHK("released", 1'b1, off)
    `CHK("cal seen", (first || n >= 17), cal_seen)
    if ((first && n >= 16) || n >= 32) ofs = $signed(offset_meas);
    first = 1'b0;
  endtask

  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Watchdog
  initial begin
    #2000000;
    num_errors++;
    give_verdict();
  end

  // ==========================================================
  // Main sequence
  initial begin
    seed = 52;
    num_errors = 0;
    num_checks = 0;
    sample_valid = 1'b0;
    sample_data = '0;
    offset_meas = '0;
    cal_seen = 1'b0;
    do_reset();
    `CHK("oe idle", 1'b1, spi_out.sdo_oe_n)
    `CHK("ready idle", 1'b1, sample_ready)
    set_ofs(13'h0005);
    frame(16);
    push(RES_MAX);
    push(RES_EMPTY);
    frame(14);
    frame(14);
    for (int i = 0; i < 8; i++) begin
      push(12'($random(seed)));
      set_ofs(13'($random(seed) % 64));
      frame(14 + ($random(seed) & 31));
    end
    set_ofs(13'h0003);
    push(12'h800);
    frame(31);
    push(12'h800);
    frame(32);
    push(12'h800);
    frame(14);
    for (int i = 0; i < 18; i++) push(12'($random(seed)));
    `CHK("fifo full", 1'b0, sample_ready)
    for (int i = 0; i < 17; i++) frame(14);
    `CHK("fifo empty", 1'b1, sample_ready)
    do_reset();
    set_ofs(13'h0011);
    frame(10);
    push(RES_MAX);
    frame(14);
    set_ofs(13'h1ffb);
    push(12'hffe);
    frame(32);
    push(12'hffe);
    frame(14);
    give_verdict();
  end
endmodule // adc_offset_calibration_frame_tb_top

// ---- oc_frame_ctrl.sv ----
// Sample FIFO and serial frame controller with offset calibration.
// Assumes cs_n and sclk come from an external host, asynchronous
// to ref_clk, with sclk slow enough to be sampled by ref_clk.
`timescale 1ns/10ps

// ==========================================================
// Sample FIFO
module oc_fifo #(
  parameter int W     = 12,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic         full;
  logic         empty;

  assign empty     = (wr_ptr == rd_ptr);
  assign full      = (wr_ptr[AW] != rd_ptr[AW]) &&
                     (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge ref_clk) begin
    if (in_valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
    end else if (in_valid && !full) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr <= '0;
    end else if (out_ready && !empty) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule // oc_fifo

// How it works
// - First select fall after reset calibrates
// - Power-up calibration needs 16 clock falls
// - Output held low during calibration
// - Short first frame keeps stored offset
// - Later results corrected by stored offset
// - Power-up calibration lasts at least 15 periods
// - Recalibration needs 32 falls in frame
// - First 14 clocks convert and shift result
// - Recalibration runs fall 17 to 32
// - Output low after 14th fall
// - Select high releases the output
// - Short normal frame keeps stored offset
// - Zero, zero, then result on falls
// - Offset store resets to zero, hidden
// - Result is 12-bit straight binary
module oc_frame_ctrl
  import oc_pkg::*;
(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Serial pins to and from host
  input  wire oc_spi_in_t       spi_in,
  output oc_sdo_t               spi_out,
  // Raw samples from converter core
  input  wire logic             sample_valid,
  output logic                  sample_ready,
  input  wire logic [RES_W-1:0] sample_data,
  // Offset measured by calibration core
  input  wire logic [OFS_W-1:0] offset_meas,
  // Status
  output logic                  cal_active
);

  // ==========================================================
  // Correction arithmetic
  function automatic logic [RES_W-1:0] oc_correct(
    input logic [RES_W-1:0] raw,
    input logic [OFS_W-1:0] ofs
  );
    logic [RES_W+1:0] diff;
    diff = {2'b00, raw} - {ofs[OFS_W-1], ofs};
    if (diff[RES_W+1]) begin
      oc_correct = RES_EMPTY;
    end else if (diff[RES_W]) begin
      oc_correct = RES_MAX;
    end else begin
      oc_correct = diff[RES_W-1:0];
    end
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic cs_ff1;
  logic cs_s;
  logic cs_q;
  logic sclk_ff1;
  logic sclk_s;
  logic sclk_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_ff1 <= 1'b1;
      cs_s   <= 1'b1;
      cs_q   <= 1'b1;
    end else begin
      cs_ff1 <= spi_in.cs_n;
      cs_s   <= cs_ff1;
      cs_q   <= cs_s;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_ff1 <= 1'b0;
      sclk_s   <= 1'b0;
      sclk_q   <= 1'b0;
    end else begin
      sclk_ff1 <= spi_in.sclk;
      sclk_s   <= sclk_ff1;
      sclk_q   <= sclk_s;
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;

  assign cs_fall   = cs_q && !cs_s;
  assign cs_rise   = !cs_q && cs_s;
  assign sclk_fall = sclk_q && !sclk_s && !cs_s;

  // ==========================================================
  // Sample buffer
  logic             fifo_valid;
  logic [RES_W-1:0] fifo_data;
  logic             pop;

  oc_fifo #(
    .W     (RES_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   (sample_data),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data)
  );

  // ==========================================================
  // Frame state
  oc_state_t        state;
  oc_state_t        next_state;
  logic             first_frame;
  logic [CNT_W-1:0] fall_cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             upd_evt;

  assign pop      = cs_fall && !first_frame;
  assign next_cnt = (fall_cnt == FALL_CNT_MAX) ? fall_cnt
                                               : fall_cnt + 1'b1;

  assign upd_evt = sclk_fall &&
    (((state == ST_PWRCAL) && (next_cnt == FALL_PWR_DONE)) ||
     ((state == ST_RECAL) && (next_cnt == FALL_RECAL_DONE)));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_frame <= 1'b1;
    end else if (cs_fall) begin
      first_frame <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fall_cnt <= '0;
    end else if (cs_fall) begin
      fall_cnt <= '0;
    end else if (sclk_fall) begin
      fall_cnt <= next_cnt;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cs_fall && first_frame) begin
          next_state = ST_PWRCAL;
        end else if (cs_fall) begin
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (cs_rise) begin
          next_state = ST_IDLE;
        end else if (sclk_fall &&
                     (next_cnt == FALL_RECAL_START)) begin
          next_state = ST_RECAL;
        end
      end
      ST_RECAL: begin
        if (cs_rise || upd_evt) begin
          next_state = ST_IDLE;
        end
      end
      ST_PWRCAL: begin
        if (cs_rise || upd_evt) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_active <= 1'b0;
    end else begin
      cal_active <= (next_state == ST_PWRCAL) ||
                    (next_state == ST_RECAL);
    end
  end

  // ==========================================================
  // Offset correction store
  logic [OFS_W-1:0] store;

  // Cleared at reset, no serial access
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      store <= OFS_RESET;
    end else if (upd_evt) begin
      store <= offset_meas;
    end
  end

  // ==========================================================
  // Serial output
  logic [RES_W-1:0] shreg;
  logic [RES_W-1:0] raw_now;

  assign raw_now = fifo_valid ? fifo_data : RES_EMPTY;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shreg <= '0;
    end else if (pop) begin
      shreg <= oc_correct(raw_now, store);
    end else if (sclk_fall && (state == ST_SHIFT) &&
                 (next_cnt > FALL_FIRST_DATA) &&
                 (next_cnt <= FALL_LAST_DATA)) begin
      shreg <= {shreg[RES_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_out.sdo <= 1'b0;
    end else if (cs_fall) begin
      spi_out.sdo <= 1'b0;
    end else if (sclk_fall && (state == ST_SHIFT) &&
                 (next_cnt > FALL_FIRST_DATA) &&
                 (next_cnt <= FALL_LAST_DATA)) begin
      // Result bits on falls 2 to 13
      spi_out.sdo <= shreg[RES_W-1];
    end else if (sclk_fall) begin
      spi_out.sdo <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_out.sdo_oe_n <= 1'b1;
    end else if (cs_fall) begin
      spi_out.sdo_oe_n <= 1'b0;
    end else if (cs_rise) begin
      spi_out.sdo_oe_n <= 1'b1;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_first_cal_entry: assert property (
    cs_fall && first_frame |=> state == ST_PWRCAL)
    else $error("first frame did not calibrate");

  a_pwr_cal_done: assert property (
    (state == ST_PWRCAL) && sclk_fall && (fall_cnt == 6'h0f)
    |=> (store == $past(offset_meas)) && (state == ST_IDLE))
    else $error("power-up calibration not stored");

  a_cal_sdo_low: assert property (
    (state == ST_PWRCAL) |-> !spi_out.sdo)
    else $error("output high during calibration");

  a_store_hold: assert property (
    !upd_evt |=> $stable(store))
    else $error("offset store changed without completion");

  a_recal_done: assert property (
    (state == ST_RECAL) && sclk_fall && (fall_cnt == 6'h1f)
    |=> store == $past(offset_meas))
    else $error("recalibration not stored at fall 32");

  a_recal_start: assert property (
    (state == ST_SHIFT) && sclk_fall && (fall_cnt == 6'h10)
    && !cs_rise |=> state == ST_RECAL)
    else $error("recalibration did not start at fall 17");

  a_tail_low: assert property (
    (state != ST_IDLE) && (fall_cnt >= FALL_DATA_END)
    |-> !spi_out.sdo)
    else $error("output high after fall 14");

  a_release_hiz: assert property (
    cs_rise |=> spi_out.sdo_oe_n)
    else $error("output not released");

  a_lead_zero: assert property (
    cs_fall && !first_frame
    |=> !spi_out.sdo && !spi_out.sdo_oe_n)
    else $error("leading zero missing");

  a_data_bit: assert property (
    (state == ST_SHIFT) && sclk_fall && (fall_cnt >= 6'h01)
    && (fall_cnt <= 6'h0c) |=> spi_out.sdo == $past(shreg[11]))
    else $error("data bit mismatch");

  c_pwr_cal: cover property (
    (state == ST_PWRCAL) ##1 upd_evt);
  c_recal: cover property (
    (state == ST_RECAL) && upd_evt);
  c_short_frame: cover property (
    (state == ST_SHIFT) && cs_rise);
  c_fifo_full: cover property (!sample_ready);

endmodule // oc_frame_ctrl

// ---- oc_host_model.sv ----
// Behavioural host that plays the serial master for the frame block.
// Assumes the bench calls run_frame one frame at a time.
`timescale 1ns/10ps

// ==========================================================
// Host serial master
module oc_host_model
  import oc_pkg::*;
(
  // Host pins
  output logic      cs_n,
  output logic      sclk,
  // Device pins
  input  wire logic sdo,
  input  wire logic sdo_oe_n
);
  localparam int HALF_NS = 160;
  localparam int GAP_NS  = 400;

  // Clock stands still high outside frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
  end

  // ==========================================================
  // One frame of n falls, sdo sampled before each fall
  // Host supplies falls
  task automatic run_frame(input int n, output logic [63:0] bits,
                           output logic oe_on, output logic oe_off);
    bits = '0;
    cs_n = 1'b0;
    #(GAP_NS);
    oe_on = sdo_oe_n;
    for (int i = 0; i < n; i++) begin
      bits[i] = sdo;
      sclk = 1'b0;
      #(HALF_NS);
      sclk = 1'b1;
      #(HALF_NS);
    end
    bits[n] = sdo;
    cs_n = 1'b1;
    #(GAP_NS);
    oe_off = sdo_oe_n;
  endtask
endmodule // oc_host_model

// ---- oc_pkg.sv ----
// Shared constants and types for the offset calibration frame block.
// Assumes a 25 MHz system clock that samples the serial pins.
package oc_pkg;

  // ==========================================================
  // Widths and FIFO depth
  localparam int RES_W      = 12;
  localparam int OFS_W      = 13;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W      = 6;

  // ==========================================================
  // Frame edge counts
  localparam logic [CNT_W-1:0] FALL_FIRST_DATA  = 6'h01;
  localparam logic [CNT_W-1:0] FALL_LAST_DATA   = 6'h0d;
  localparam logic [CNT_W-1:0] FALL_DATA_END    = 6'h0e;
  localparam logic [CNT_W-1:0] FALL_PWR_DONE    = 6'h10;
  localparam logic [CNT_W-1:0] FALL_RECAL_START = 6'h11;
  localparam logic [CNT_W-1:0] FALL_RECAL_DONE  = 6'h20;
  localparam logic [CNT_W-1:0] FALL_CNT_MAX     = 6'h3f;
  localparam int               POWERUP_CAL_SCLKS = 15;

  // ==========================================================
  // Timing
  localparam int CLK_NS  = 40;
  localparam int ACQ_NS  = 200;
  localparam int ACQ_CYC = (ACQ_NS + CLK_NS - 1) / CLK_NS;
  localparam int CAL_SCLK_MHZ_HI = 16;
  localparam int CAL_SCLK_MHZ_LO = 12;

  // ==========================================================
  // Reset and clamp values
  localparam logic [OFS_W-1:0] OFS_RESET   = 13'h0000;
  localparam logic [RES_W-1:0] RES_MAX     = 12'hfff;
  localparam logic [RES_W-1:0] RES_EMPTY   = 12'h000;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_RECAL = 2'b11,
    ST_PWRCAL = 2'b10
  } oc_state_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
  } oc_spi_in_t;

  typedef struct packed {
    logic sdo;
    logic sdo_oe_n;
  } oc_sdo_t;

endpackage
